// >>> include/axis_cfg.svh
`ifndef AXIS_CFG_SVH
`define AXIS_CFG_SVH

// Register byte offsets
`define ADDR_W 8
`define OFF_CTRL 8'h00
`define OFF_MASK 8'h04
`define OFF_PEND 8'h08
`define OFF_ERRP 8'h0c
`define OFF_CMD 8'h10
`define OFF_FB 8'h14
`define OFF_ERR 8'h18
`define OFF_GEN 8'h1c
`define OFF_LATCH 8'h20
`define OFF_STAT 8'h24

// Control register fields
`define CTRL_IRQ_EN 0
`define CTRL_GEN_LSB 1
`define CTRL_GEN_MSB 2
`define CTRL_FB_SRC 3
`define CTRL_RESET 32'h0000_0004

// Factor mask: writable bits and reset value
`define MASK_VALID 32'h0005_fff7
`define MASK_RESET 32'h0000_0000

// Factor event bit positions
`define EV_CLR 13
`define EV_LTC 14
`define EV_ORG 15
`define EV_SD 16
`define EV_START 18

// Counter widths
`define POS_W 28
`define ERR_W 16
`define MOTION_EV_W 13

// Timer tick for the general counter
`define CLK_PERIOD_NS 10
`define GEN_TICK_NS 20
`define GEN_TICK_CYC (`GEN_TICK_NS / `CLK_PERIOD_NS)
`define TICK_W 4

`endif

// >>> include/axis_pkg.sv
package axis_pkg;

    // General counter count source
    typedef enum logic [1:0] {GEN_CMD, GEN_ENC, GEN_PLS, GEN_TICK} gen_src_t;

    // Counter end behaviour
    typedef enum logic {CNT_WRAP, CNT_SAT} cnt_mode_t;

endpackage : axis_pkg

// >>> logic/axis_quad_decode.sv
`timescale 1ns/10ps
`default_nettype none

module axis_quad_decode
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Encoder phases, A in bit 1, B in bit 0
    input wire logic [1:0] phase,
    // Count pulses
    output logic up_q,
    output logic dn_q
);
    import axis_pkg::*;

    logic [1:0] prev_q;
    logic step;
    logic fwd;

    // Four-edge decode; a double change is a glitch and counts nothing
    assign step = phase[1] ^ prev_q[1] ^ phase[0] ^ prev_q[0];
    assign fwd = phase[1] ^ prev_q[0];

    // Previous phase state
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            prev_q <= 2'h0;
        else
            prev_q <= phase;
    end

    // Registered count pulses
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            up_q <= 1'b0;
            dn_q <= 1'b0;
        end
        else
        begin
            up_q <= step & fwd;
            dn_q <= step & ~fwd;
        end
    end

endmodule : axis_quad_decode

`default_nettype wire

// >>> logic/axis_counter.sv
`timescale 1ns/10ps
`default_nettype none

module axis_counter
#(
    parameter int W = 28
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire axis_pkg::cnt_mode_t mode,
    input wire logic clr,
    input wire logic load,
    input wire logic [W-1:0] load_val,
    input wire logic up,
    input wire logic dn,
    // Value
    output logic [W-1:0] count_q
);
    import axis_pkg::*;

    localparam logic [W-1:0] MAXV = {1'b0, {(W-1){1'b1}}};
    localparam logic [W-1:0] MINV = {1'b1, {(W-1){1'b0}}};

    logic at_max;
    logic at_min;

    // Saturating mode stops at the signed limits
    assign at_max = (mode == CNT_SAT) && (count_q == MAXV);
    assign at_min = (mode == CNT_SAT) && (count_q == MINV);

    // Clear beats load, load beats counting
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            count_q <= '0;
        else if (clr)
            count_q <= '0;
        else if (load)
            count_q <= load_val;
        else if (up && !dn && !at_max)
            count_q <= count_q + 1'b1;
        else if (dn && !up && !at_min)
            count_q <= count_q - 1'b1;
    end

endmodule : axis_counter

`default_nettype wire

// >>> logic/axis_interrupt_and_counters.sv
// How it works
// - Card-wide enable: 0 blocks every host interrupt, 1 lets them through.
// - With enable on, error causes always interrupt; no mask can hide them.
// - Per-axis factor mask: bit 1 enables that event, bit 0 disables it.
// - Bit 0 normal stop, bit 1 next command starts, bit 2 buffer empty.
// - Bits 4 to 7: accel start, accel end, decel start, decel end.
// - Bits 8 to 12: comparator 1 through comparator 5 hits.
// - Bit 13 clear-input reset, bit 14 latch-input, bit 15 origin latch.
// - Bit 16 slow-down on; bit 18 sync start or start-all on.
// - Feedback counter 28-bit signed; source encoder or own pulses.
// - Command counter counts own pulses, 28-bit signed, read and write.
// - Host write to feedback counter replaces value; counting resumes.
// - Error counter 16-bit signed, readable, held within its range.
// - Host clear command sets the error counter to zero.
// - General source: 0 command, 1 encoder, 2 pulse input, 3 tick.
// - General counter starts on pulse input; host sets source, loads, reads.
`include "axis_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module axis_interrupt_and_counters
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [`ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata_q,
    // Motion core
    input wire logic pulse_out_step,
    input wire logic pulse_out_dir,
    input wire logic [`MOTION_EV_W-1:0] motion_events,
    input wire logic start_all_cmd,
    input wire logic error_event,
    // Field inputs
    input wire logic [1:0] encoder_phase_inputs,
    input wire logic pulse_in_step,
    input wire logic pulse_in_dir,
    input wire logic clr_input,
    input wire logic latch_input,
    input wire logic origin_input,
    input wire logic slow_down_input,
    input wire logic sync_start_input,
    // Host side outputs
    output logic irq_q,
    output axis_pkg::gen_src_t gen_source_q
);
    import axis_pkg::*;

    // Sign extend a position value to the bus width
    function automatic logic [31:0] sext_pos(input logic [`POS_W-1:0] v);
        return {{(32 - `POS_W){v[`POS_W-1]}}, v};
    endfunction : sext_pos

    // Register address match
    function automatic logic hit(input logic [`ADDR_W-1:0] a,
                                 input logic [`ADDR_W-1:0] off);
        return a == off;
    endfunction : hit

    logic card_irq_enable_q;
    logic fb_src_own_q;
    logic [31:0] mask_q;
    logic [31:0] pend_q;
    logic err_pend_q;
    logic [4:0] prev_q;
    logic [`POS_W-1:0] latch_q;
    logic [`TICK_W-1:0] tick_cnt_q;
    logic tick_q;
    logic [31:0] rdata_d;
    logic [31:0] ev;
    logic [31:0] ev_hit;
    logic clr_rise;
    logic ltc_rise;
    logic org_rise;
    logic sd_rise;
    logic sta_rise;
    logic wr_ctrl;
    logic wr_mask;
    logic wr_pend;
    logic wr_errp;
    logic wr_cmd;
    logic wr_fb;
    logic wr_err;
    logic wr_gen;
    logic cmd_up;
    logic cmd_dn;
    logic enc_up;
    logic enc_dn;
    logic fb_up;
    logic fb_dn;
    logic err_up;
    logic err_dn;
    logic gen_up;
    logic gen_dn;
    logic signed [2:0] err_delta;
    logic [`POS_W-1:0] cmd_cnt;
    logic [`POS_W-1:0] fb_cnt;
    logic [`ERR_W-1:0] err_cnt;
    logic [`POS_W-1:0] gen_cnt;

    // Write strobes per register
    assign wr_ctrl = wr && hit(addr, `OFF_CTRL);
    assign wr_mask = wr && hit(addr, `OFF_MASK);
    assign wr_pend = wr && hit(addr, `OFF_PEND);
    assign wr_errp = wr && hit(addr, `OFF_ERRP);
    assign wr_cmd = wr && hit(addr, `OFF_CMD);
    assign wr_fb = wr && hit(addr, `OFF_FB);
    assign wr_err = wr && hit(addr, `OFF_ERR);
    assign wr_gen = wr && hit(addr, `OFF_GEN);

    // Rising edges of the field inputs
    assign clr_rise = clr_input & ~prev_q[0];
    assign ltc_rise = latch_input & ~prev_q[1];
    assign org_rise = origin_input & ~prev_q[2];
    assign sd_rise = slow_down_input & ~prev_q[3];
    assign sta_rise = sync_start_input & ~prev_q[4];

    // Previous field input levels
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            prev_q <= 5'h00;
        else
            prev_q <= {sync_start_input, slow_down_input, origin_input,
                       latch_input, clr_input};
    end

    // Control register: enable, general source, feedback source
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            card_irq_enable_q <= 1'((`CTRL_RESET >> `CTRL_IRQ_EN) & 32'h1);
            gen_source_q <= GEN_PLS;
            fb_src_own_q <= 1'b0;
        end
        else if (wr_ctrl)
        begin
            card_irq_enable_q <= wdata[`CTRL_IRQ_EN];
            gen_source_q <= gen_src_t'(wdata[`CTRL_GEN_MSB:`CTRL_GEN_LSB]);
            fb_src_own_q <= wdata[`CTRL_FB_SRC];
        end
    end

    // Factor mask; reserved positions are not stored
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            mask_q <= `MASK_RESET;
        else if (wr_mask)
            mask_q <= wdata & `MASK_VALID;
    end

    // Factor event map
    always_comb
    begin
        ev = 32'h0000_0000;
        ev[2:0] = motion_events[2:0];
        ev[7:4] = motion_events[7:4];
        ev[12:8] = motion_events[12:8];
        ev[`EV_CLR] = clr_rise;
        ev[`EV_LTC] = ltc_rise;
        ev[`EV_ORG] = org_rise;
        ev[`EV_SD] = sd_rise;
        ev[`EV_START] = sta_rise | start_all_cmd;
    end

    // Only enabled factors reach the pending flags
    assign ev_hit = ev & mask_q;

    // Pending flags, write one to clear, a new event wins
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            pend_q <= 32'h0000_0000;
        else if (wr_pend)
            pend_q <= (pend_q & ~wdata) | ev_hit;
        else
            pend_q <= pend_q | ev_hit;
    end

    // Error pending flag, never masked
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            err_pend_q <= 1'b0;
        else if (wr_errp && wdata[0])
            err_pend_q <= error_event;
        else
            err_pend_q <= err_pend_q | error_event;
    end

    // Host interrupt request
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            irq_q <= 1'b0;
        else
            irq_q <= card_irq_enable_q & ((|pend_q) | err_pend_q);
    end

    // Timer tick for the general counter
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            tick_cnt_q <= '0;
            tick_q <= 1'b0;
        end
        else if (tick_cnt_q == `TICK_W'(`GEN_TICK_CYC - 1))
        begin
            tick_cnt_q <= '0;
            tick_q <= 1'b1;
        end
        else
        begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
            tick_q <= 1'b0;
        end
    end

    // Count pulse steering
    assign cmd_up = pulse_out_step & pulse_out_dir;
    assign cmd_dn = pulse_out_step & ~pulse_out_dir;
    assign fb_up = fb_src_own_q ? cmd_up : enc_up;
    assign fb_dn = fb_src_own_q ? cmd_dn : enc_dn;

    // Error is command minus feedback; only the net sign counts
    assign err_delta = 3'(signed'({2'b00, cmd_up})) - 3'(signed'({2'b00, cmd_dn}))
                     - 3'(signed'({2'b00, fb_up})) + 3'(signed'({2'b00, fb_dn}));
    assign err_up = err_delta > 3'sd0;
    assign err_dn = err_delta < 3'sd0;

    // General counter source select
    always_comb
    begin
        gen_up = 1'b0;
        gen_dn = 1'b0;
        unique case (gen_source_q)
            GEN_CMD:
            begin
                gen_up = cmd_up;
                gen_dn = cmd_dn;
            end
            GEN_ENC:
            begin
                gen_up = enc_up;
                gen_dn = enc_dn;
            end
            GEN_PLS:
            begin
                gen_up = pulse_in_step & pulse_in_dir;
                gen_dn = pulse_in_step & ~pulse_in_dir;
            end
            GEN_TICK:
                gen_up = tick_q;
        endcase
    end

    // Encoder phase decoder
    axis_quad_decode u_quad (
        .clk(clk),
        .rst_n(rst_n),
        .phase(encoder_phase_inputs),
        .up_q(enc_up),
        .dn_q(enc_dn)
    );

    // Command position counter
    axis_counter #(.W(`POS_W)) u_cmd (
        .clk(clk),
        .rst_n(rst_n),
        .mode(CNT_WRAP),
        .clr(clr_rise),
        .load(wr_cmd),
        .load_val(wdata[`POS_W-1:0]),
        .up(cmd_up),
        .dn(cmd_dn),
        .count_q(cmd_cnt)
    );

    // Feedback position counter
    axis_counter #(.W(`POS_W)) u_fb (
        .clk(clk),
        .rst_n(rst_n),
        .mode(CNT_WRAP),
        .clr(clr_rise),
        .load(wr_fb),
        .load_val(wdata[`POS_W-1:0]),
        .up(fb_up),
        .dn(fb_dn),
        .count_q(fb_cnt)
    );

    // Position error counter, saturating
    axis_counter #(.W(`ERR_W)) u_err (
        .clk(clk),
        .rst_n(rst_n),
        .mode(CNT_SAT),
        .clr(clr_rise | wr_err),
        .load(1'b0),
        .load_val('0),
        .up(err_up),
        .dn(err_dn),
        .count_q(err_cnt)
    );

    // General counter
    axis_counter #(.W(`POS_W)) u_gen (
        .clk(clk),
        .rst_n(rst_n),
        .mode(CNT_WRAP),
        .clr(clr_rise),
        .load(wr_gen),
        .load_val(wdata[`POS_W-1:0]),
        .up(gen_up),
        .dn(gen_dn),
        .count_q(gen_cnt)
    );

    // Feedback value caught on latch or origin edge
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            latch_q <= '0;
        else if (ltc_rise || org_rise)
            latch_q <= fb_cnt;
    end

    // Read multiplexer
    always_comb
    begin
        rdata_d = 32'h0000_0000;
        case (addr)
            `OFF_CTRL:
            begin
                rdata_d[`CTRL_IRQ_EN] = card_irq_enable_q;
                rdata_d[`CTRL_GEN_MSB:`CTRL_GEN_LSB] = gen_source_q;
                rdata_d[`CTRL_FB_SRC] = fb_src_own_q;
            end
            `OFF_MASK: rdata_d = mask_q;
            `OFF_PEND: rdata_d = pend_q;
            `OFF_ERRP: rdata_d[0] = err_pend_q;
            `OFF_CMD: rdata_d = sext_pos(cmd_cnt);
            `OFF_FB: rdata_d = sext_pos(fb_cnt);
            `OFF_ERR: rdata_d = {{(32 - `ERR_W){err_cnt[`ERR_W-1]}}, err_cnt};
            `OFF_GEN: rdata_d = sext_pos(gen_cnt);
            `OFF_LATCH: rdata_d = sext_pos(latch_q);
            `OFF_STAT: rdata_d[0] = irq_q;
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    // Read data stand one cycle only
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            rdata_q <= 32'h0000_0000;
        else if (rd)
            rdata_q <= rdata_d;
        else
            rdata_q <= 32'h0000_0000;
    end

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_irq_gate_off: assert property (!card_irq_enable_q |=> !irq_q)
        else $error("interrupt raised while card enable off");

    a_error_unmasked: assert property (
        error_event && card_irq_enable_q && !wr_ctrl |=> ##1 irq_q)
        else $error("error event did not reach host");

    a_mask_blocks: assert property (
        !wr_pend && ((ev & ~mask_q) != 32'h0) && (ev_hit == 32'h0)
        |=> pend_q == $past(pend_q))
        else $error("masked event changed pending flags");

    a_stop_bit0: assert property (
        motion_events[0] && mask_q[0] |=> pend_q[0])
        else $error("normal stop not pending");

    a_accel_bit4: assert property (
        motion_events[4] && mask_q[4] |=> pend_q[4])
        else $error("acceleration start not pending");

    a_cmp5_bit12: assert property (
        motion_events[12] && mask_q[12] |=> pend_q[12])
        else $error("trigger comparator hit not pending");

    a_clr_bit13: assert property (
        $rose(clr_input) && mask_q[`EV_CLR] |=> pend_q[`EV_CLR])
        else $error("clear input event not pending");

    a_start_bit18: assert property (
        start_all_cmd && mask_q[`EV_START] |=> pend_q[`EV_START])
        else $error("start event not pending");

    a_mask_reserved: assert property (
        (mask_q & ~`MASK_VALID) == 32'h0)
        else $error("reserved mask bit stored");

    a_fb_load: assert property (
        wr_fb && !clr_rise |=> fb_cnt == $past(wdata[`POS_W-1:0]))
        else $error("feedback counter load lost");

    a_err_clear: assert property (wr_err |=> err_cnt == '0)
        else $error("error counter not cleared");

    a_irq_follows: assert property (
        card_irq_enable_q && (|pend_q) && !wr_ctrl |=> irq_q)
        else $error("pending flag did not raise interrupt");

    c_irq_raised: cover property (!irq_q ##1 irq_q);
    c_pend_clear: cover property (wr_pend && (pend_q != 32'h0));
    c_err_sat: cover property (err_cnt == 16'h7fff && err_up);
    c_tick_count: cover property (gen_source_q == GEN_TICK && tick_q);

endmodule : axis_interrupt_and_counters

`default_nettype wire

// >>> verif/axis_field_model.sv
`timescale 1ns/10ps
`default_nettype none

module axis_field_model
(
    // Clock
    input wire logic clk,
    // Move request
    input wire logic go,
    input wire logic up,
    input wire logic [7:0] edges,
    // Encoder side
    output logic [1:0] phase,
    output logic busy
);
    logic [1:0] idx;
    integer i;

    // Quadrature walk, A leads B going up, still between moves
    initial
    begin
        phase = 2'h0;
        busy = 1'b0;
        idx = 2'h0;
        forever
        begin
            @(posedge clk);
            if (go)
            begin
                busy <= 1'b1;
                for (i = 0; i < edges; i++)
                begin
                    repeat (4) @(posedge clk);
                    idx = up ? idx + 2'h1 : idx - 2'h1;
                    phase <= {idx[1] ^ idx[0], idx[1]};
                end
                repeat (4) @(posedge clk);
                busy <= 1'b0;
            end
        end
    end
endmodule : axis_field_model

`default_nettype wire

// >>> verif/testbench.sv
`include "axis_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module testbench;
    import axis_pkg::*;
    logic clk, rst_n, wr, rd, go, up, busy, irq_q;
    logic [`ADDR_W-1:0] addr;
    logic [31:0] wdata, rdata_q, v, w;
    logic pulse_out_step, pulse_out_dir, start_all_cmd, error_event;
    logic pulse_in_step, pulse_in_dir;
    logic [`MOTION_EV_W-1:0] motion_events;
    logic [1:0] encoder_phase_inputs;
    logic [4:0] fin;
    logic [7:0] edges;
    gen_src_t gen_source_q;
    int n_errors, checks, i;
    int fbit[6] = '{13, 14, 15, 16, 18, 18};
    int gexp[3] = '{3, 4, 3};

    // Clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    axis_interrupt_and_counters u_axis_interrupt_and_counters
    (
        .clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata_q,
        .pulse_out_step, .pulse_out_dir, .motion_events,
        .start_all_cmd, .error_event, .encoder_phase_inputs,
        .pulse_in_step, .pulse_in_dir,
        .clr_input(fin[0]), .latch_input(fin[1]),
        .origin_input(fin[2]), .slow_down_input(fin[3]),
        .sync_start_input(fin[4]), .irq_q, .gen_source_q
    );

    axis_field_model u_axis_field_model
    (
        .clk, .go, .up, .edges, .phase(encoder_phase_inputs), .busy
    );

    // Compare and count
    task automatic chk(input string s, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask : chk

    // One-cycle register write
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    // One-cycle register read, data in the next cycle
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata_q;
    endtask : rd_reg

    task automatic chk_reg(input logic [7:0] a, input logic [31:0] e,
                           input string s);
        logic [31:0] d;
        rd_reg(a, d);
        chk(s, e, d);
    endtask : chk_reg

    // Burst of step pulses on own output or pulse input
    task automatic pulses(input bit pin, input bit dir, input int n);
        pulse_out_dir <= dir;
        pulse_in_dir <= dir;
        repeat (n)
        begin
            @(posedge clk);
            if (pin)
                pulse_in_step <= 1'b1;
            else
                pulse_out_step <= 1'b1;
        end
        @(posedge clk);
        pulse_in_step <= 1'b0;
        pulse_out_step <= 1'b0;
    endtask : pulses

    // Encoder move through the field model
    task automatic enc(input bit dir, input int n);
        @(posedge clk);
        go <= 1'b1;
        up <= dir;
        edges <= n[7:0];
        @(posedge clk);
        go <= 1'b0;
        #1;
        while (busy)
            @(posedge clk);
    endtask : enc

    // One-cycle event pulse, 99 for the error cause
    task automatic ev(input int b);
        @(posedge clk);
        if (b == 99)
            error_event <= 1'b1;
        else
            motion_events[b] <= 1'b1;
        @(posedge clk);
        error_event <= 1'b0;
        motion_events <= '0;
        repeat (2) @(posedge clk);
        #1;
    endtask : ev

    task automatic irq_within(input int n);
        #1;
        for (int k = 0; k < n && irq_q !== 1'b1; k++)
        begin
            @(posedge clk);
            #1;
        end
        chk("irq_q", 1, irq_q);
    endtask : irq_within

    task final_report;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report

    // Watchdog
    initial
    begin
        #700000;
        n_errors++;
        $display("[FAIL] run expected done seen hang");
        final_report;
    end

    // Test sequence
    initial
    begin
        {rst_n, wr, rd, addr, wdata, go, up, edges, fin} = '0;
        {pulse_out_step, start_all_cmd, error_event, pulse_in_step} = '0;
        {pulse_out_dir, pulse_in_dir, motion_events} = '0;
        n_errors = 0;
        checks = 0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk("gen_source_q", GEN_PLS, gen_source_q);
        chk("irq_q", 0, irq_q);
        chk_reg(`OFF_CTRL, `CTRL_RESET, "ctrl");
        @(posedge clk);
        #1;
        chk("rdata_q idle", 0, rdata_q);
        chk_reg(`OFF_MASK, 0, "mask");
        wr_reg(`OFF_MASK, 32'hffff_ffff);
        chk_reg(`OFF_MASK, `MASK_VALID, "mask");
        wr_reg(8'h40, 32'h1234_5678);
        chk_reg(8'h40, 0, "unmapped");
        // Masked event leaves no trace
        wr_reg(`OFF_MASK, 0);
        wr_reg(`OFF_CTRL, 32'h5);
        ev(4);
        chk_reg(`OFF_PEND, 0, "pend");
        chk("irq_q", 0, irq_q);
        // Every motion factor alone
        for (i = 0; i < 13; i++)
            if (i != 3)
            begin
                wr_reg(`OFF_MASK, 32'h1 << i);
                ev(i);
                chk("irq_q", 1, irq_q);
                chk_reg(`OFF_PEND, 32'h1 << i, "pend");
                wr_reg(`OFF_PEND, 32'h1 << i);
            end
        // Card enable gates delivery
        wr_reg(`OFF_MASK, 32'h1);
        wr_reg(`OFF_CTRL, 32'h4);
        ev(0);
        chk("irq_q", 0, irq_q);
        chk_reg(`OFF_PEND, 32'h1, "pend");
        wr_reg(`OFF_CTRL, 32'h5);
        irq_within(3);
        chk_reg(`OFF_STAT, 32'h1, "stat");
        wr_reg(`OFF_PEND, 32'h1);
        repeat (3) @(posedge clk);
        #1;
        chk("irq_q", 0, irq_q);
        // Error cause with every mask bit off
        wr_reg(`OFF_MASK, 0);
        ev(99);
        chk("irq_q", 1, irq_q);
        chk_reg(`OFF_ERRP, 32'h1, "errp");
        wr_reg(`OFF_ERRP, 32'h1);
        // Field inputs and start-all
        wr_reg(`OFF_MASK, `MASK_VALID);
        wr_reg(`OFF_FB, 32'h0000_0123);
        for (i = 5; i >= 0; i--)
        begin
            @(posedge clk);
            if (i == 5)
                start_all_cmd <= 1'b1;
            else
                fin[i] <= 1'b1;
            @(posedge clk);
            start_all_cmd <= 1'b0;
            irq_within(8);
            chk_reg(`OFF_PEND, 32'h1 << fbit[i], "pend");
            @(posedge clk);
            fin <= '0;
            wr_reg(`OFF_PEND, 32'h0005_e000);
        end
        chk_reg(`OFF_LATCH, 32'h0000_0123, "latch");
        chk_reg(`OFF_FB, 0, "fb");
        // Command counter wraps both ways
        wr_reg(`OFF_CMD, 32'h07ff_fffe);
        pulses(0, 1, 2);
        chk_reg(`OFF_CMD, 32'hf800_0000, "cmd");
        pulses(0, 0, 3);
        chk_reg(`OFF_CMD, 32'h07ff_fffd, "cmd");
        // Feedback from own pulses, then encoder
        wr_reg(`OFF_CTRL, 32'hd);
        wr_reg(`OFF_FB, 32'hffff_fff0);
        pulses(0, 1, 5);
        chk_reg(`OFF_FB, 32'hffff_fff5, "fb");
        wr_reg(`OFF_CTRL, 32'h5);
        enc(1, 8);
        chk_reg(`OFF_FB, 32'hffff_fffd, "fb");
        enc(0, 4);
        chk_reg(`OFF_FB, 32'hffff_fff9, "fb");
        // Position error counter
        wr_reg(`OFF_ERR, 0);
        pulses(0, 1, 3);
        chk_reg(`OFF_ERR, 32'h3, "err");
        enc(1, 4);
        chk_reg(`OFF_ERR, 32'hffff_ffff, "err");
        pulses(0, 1, 32770);
        chk_reg(`OFF_ERR, 32'h0000_7fff, "err");
        wr_reg(`OFF_ERR, 32'h5);
        chk_reg(`OFF_ERR, 0, "err");
        // General counter sources
        for (i = 0; i < 3; i++)
        begin
            wr_reg(`OFF_CTRL, (i << 1) | 1);
            #1;
            chk("gen_source_q", i, gen_source_q);
            wr_reg(`OFF_GEN, 0);
            if (i == 1)
                enc(1, 4);
            else
                pulses(i == 2, 1, 3);
            chk_reg(`OFF_GEN, gexp[i], "gen");
        end
        wr_reg(`OFF_CTRL, 32'h7);
        rd_reg(`OFF_GEN, v);
        repeat (18) @(posedge clk);
        rd_reg(`OFF_GEN, w);
        chk("gen tick", 32'd10, w - v);
        final_report;
    end
endmodule : testbench

`default_nettype wire
